// ### design/sfg_area_decode.v
// Area guard field decoder: is a block inside the read-only area
module sfg_area_decode (
   input wire size_16mb,
   input wire [3:0] area_guard_bits,
   input wire [4:0] block_index,
   output wire block_guarded,
   output wire any_guarded
);
   reg [4:0] lo_blk; // First guarded block
   reg [4:0] hi_blk; // Last guarded block
   reg none; // Nothing guarded

   // Range table per size
   always @* begin
      lo_blk = 5'h00;
      hi_blk = 5'h1F;
      none = 1'b0;
      if (!size_16mb) begin
         hi_blk = 5'h0F;
         case (area_guard_bits[2:0]) // R7
            3'h0: none = 1'b1;
            3'h1: lo_blk = 5'h0F;
            3'h2: lo_blk = 5'h0E;
            3'h3: lo_blk = 5'h0C;
            3'h4: lo_blk = 5'h08;
            default: lo_blk = 5'h00;
         endcase
      end else begin
         case (area_guard_bits)
            4'h0: none = 1'b1; // R8
            4'h1: lo_blk = 5'h1F; // R8
            4'h2: lo_blk = 5'h1E; // R8
            4'h3: lo_blk = 5'h1C; // R8
            4'h4: lo_blk = 5'h18; // R8
            4'h5: lo_blk = 5'h10; // R8
            4'hA: hi_blk = 5'h0F; // R9
            4'hB: hi_blk = 5'h17; // R9
            4'hC: hi_blk = 5'h1B; // R9
            4'hD: hi_blk = 5'h1D; // R9
            4'hE: hi_blk = 5'h1E; // R9
            default: lo_blk = 5'h00; // Values 6 to 9 and 15: all
         endcase
      end
   end

   // Inclusive range compare
   assign block_guarded = !none && (block_index >= lo_blk) &&
      (block_index <= hi_blk);
   assign any_guarded = !none;
endmodule // sfg_area_decode

// ### design/sfg_defines.vh
// Opcodes, status and security bit positions for the serial flash guard
`ifndef SFG_DEFINES_VH
`define SFG_DEFINES_VH

// Command opcodes
`define SFG_OP_WRITE_ALLOW 8'h06
`define SFG_OP_WRITE_FORBID 8'h04
`define SFG_OP_STATUS_WRITE 8'h01
`define SFG_OP_STATUS_READ 8'h05
`define SFG_OP_READ_ID 8'h9F
`define SFG_OP_READ 8'h03
`define SFG_OP_FAST_READ 8'h0B
`define SFG_OP_DUAL_READ 8'h3B
`define SFG_OP_SIG_READ 8'hAB
`define SFG_OP_MFR_READ 8'h90
`define SFG_OP_SECTOR_WIPE 8'h20
`define SFG_OP_BLOCK_WIPE_A 8'h52
`define SFG_OP_BLOCK_WIPE_B 8'hD8
`define SFG_OP_FULL_WIPE_A 8'h60
`define SFG_OP_FULL_WIPE_B 8'hC7
`define SFG_OP_PAGE_WRITE 8'h02
`define SFG_OP_SEC_READ 8'h2B
`define SFG_OP_SEC_WRITE 8'h2F
`define SFG_OP_OTP_ENTRY 8'hB1
`define SFG_OP_OTP_EXIT 8'hC1
`define SFG_OP_DEEP_DOWN 8'hB9

// Byte counts that close each write-type command
`define SFG_LEN_SINGLE 3'h1
`define SFG_LEN_STATUS 3'h2
`define SFG_LEN_ADDR 3'h4
`define SFG_LEN_PAGE_MIN 3'h5

// Status byte field positions
`define SFG_ST_BUSY 0
`define SFG_ST_LATCH 1
`define SFG_ST_GUARD_LO 2
`define SFG_ST_LOCK 7

// Security register bit positions
`define SFG_SEC_FACTORY 0
`define SFG_SEC_CUSTOMER 1

// Otp address split: identifier up to this, customer area up to the top
`define SFG_OTP_ID_TOP 6'h0F
`define SFG_OTP_TOP 6'h3F

// Reset values
`define SFG_RST_GUARD 4'h0
`define SFG_RST_LOCK 1'b0

`endif

// ### design/sfg_guard_core.v
// Serial flash command guard, otp lock and pause logic
// What this block does
// R1: Power-up puts command machine in standby.
// R2: Commands must end on a byte boundary.
// R3: Data-changing commands need the write latch flag.
// R4: Latch flag clears at reset and listed completions.
// R5: Deep power-down accepts only wake or signature.
// R6: Writes into guarded area are refused.
// R7: 8Mb area guard field decode.
// R8: 16Mb guard values 0 to 9 decode.
// R9: 16Mb guard values 10 to 15 decode.
// R10: Guard pin shields guard bits and lock.
// R11: Security bit 0 shows factory lock.
// R12: Otp entry, program, exit redirects accesses.
// R13: Security write sets customer lock bit 1.
// R14: Locked otp never changes again.
// R15: Otp mode blocks main array access.
// R16: Otp 00-0F identifier, 10-3F customer region.
// R17: Pause never stops a running operation.
// R18: Pause starts on pause low with clock low.
// R19: Pause ends on pause high with clock low.
// R20: Pause floats output, ignores input and clock.
// R21: Chip select high in pause resets interface.
// R22: Host resumes with pause high, select low.
// R23: Write-type commands off byte boundary rejected.
// R24: Unknown command waits in standby, output floating.
// R25: Array access ignored while operation runs.
// R26: Locked status refused while guard pin low.
`include "sfg_defines.vh"

module sfg_guard_core (
   input wire mclk,
   input wire reset_n,
   input wire cs_n,
   input wire sclk,
   input wire si,
   input wire guard_n,
   input wire pause_n,
   input wire size_16mb,
   input wire factory_locked,
   input wire op_busy,
   output wire so_out,
   output wire so_oe,
   output wire write_latch_flag,
   output wire [3:0] area_guard_bits,
   output wire status_lock_bit,
   output wire otp_mode,
   output wire customer_lock,
   output wire deep_powerdown,
   output wire pause_active,
   output wire exec_valid,
   output wire [7:0] exec_opcode,
   output wire [23:0] exec_addr,
   output wire exec_otp,
   output wire exec_otp_region,
   output wire cmd_refused
);
   // Interface states
   localparam [1:0] ST_STANDBY = 2'b00; // Waiting for select fall
   localparam [1:0] ST_CMD = 2'b01; // Taking opcode and bytes
   localparam [1:0] ST_IGNORE = 2'b10; // Bad opcode, wait for select
   localparam [1:0] ST_OUT = 2'b11; // Shifting a register out

   reg [4:0] sync1_reg; // First stage, read only by second
   reg [4:0] sync2_reg; // Second stage, safe to use
   reg sclk_prev_reg; // Previous clock level
   reg cs_prev_reg; // Previous select level
   reg [1:0] state_reg; // Interface state
   reg [1:0] state_next;
   reg [2:0] bit_cnt_reg; // Bits within current byte
   reg [2:0] byte_cnt_reg; // Whole bytes, saturating
   reg [7:0] shift_reg; // Incoming byte
   reg [7:0] opcode_reg; // First byte of command
   reg [23:0] addr_reg; // Following bytes
   reg [7:0] out_reg; // Outgoing register byte
   reg so_reg; // Output data bit
   reg pause_reg; // Pause in force
   reg pause_next;
   reg wel_reg; // Write latch flag
   reg [3:0] guard_reg; // Area guard bits
   reg lock_reg; // Status lock bit
   reg otp_reg; // Otp mode
   reg cust_lock_reg; // Customer otp lock
   reg dpd_reg; // Deep power-down
   reg exec_reg; // Execute pulse
   reg [7:0] exec_op_reg;
   reg [23:0] exec_addr_reg;
   reg exec_otp_reg;
   reg exec_region_reg;
   reg refuse_reg; // Refusal pulse

   wire s_cs = sync2_reg[0];
   wire s_sclk = sync2_reg[1];
   wire s_si = sync2_reg[2];
   wire s_guard_n = sync2_reg[3];
   wire s_pause_n = sync2_reg[4];
   wire sclk_rise = s_sclk && !sclk_prev_reg;
   wire sclk_fall = !s_sclk && sclk_prev_reg;
   wire cs_rise = s_cs && !cs_prev_reg;
   wire cs_fall = !s_cs && cs_prev_reg;
   // Clock edges count only while selected and not paused
   wire shift_en = sclk_rise && !s_cs && !pause_reg; // R20
   wire out_en = sclk_fall && !s_cs && !pause_reg; // R20
   wire byte_done = shift_en && (bit_cnt_reg == 3'h7);
   wire [7:0] new_byte = {shift_reg[6:0], s_si};

   // Guarded block of the collected address
   wire [4:0] blk = size_16mb ? addr_reg[20:16] : {1'b0, addr_reg[19:16]};
   wire blk_guarded;
   wire any_guarded;

   sfg_area_decode u_decode (
      .size_16mb(size_16mb),
      .area_guard_bits(guard_reg),
      .block_index(blk),
      .block_guarded(blk_guarded),
      .any_guarded(any_guarded)
   );

   // Opcode is one the device knows
   function known_op;
      input [7:0] op;
      begin
         case (op)
            `SFG_OP_WRITE_ALLOW, `SFG_OP_WRITE_FORBID, `SFG_OP_STATUS_WRITE,
            `SFG_OP_STATUS_READ, `SFG_OP_READ_ID, `SFG_OP_READ,
            `SFG_OP_FAST_READ, `SFG_OP_DUAL_READ, `SFG_OP_SIG_READ,
            `SFG_OP_MFR_READ, `SFG_OP_SECTOR_WIPE, `SFG_OP_BLOCK_WIPE_A,
            `SFG_OP_BLOCK_WIPE_B, `SFG_OP_FULL_WIPE_A, `SFG_OP_FULL_WIPE_B,
            `SFG_OP_PAGE_WRITE, `SFG_OP_SEC_READ, `SFG_OP_SEC_WRITE,
            `SFG_OP_OTP_ENTRY, `SFG_OP_OTP_EXIT, `SFG_OP_DEEP_DOWN:
               known_op = 1'b1;
            default: known_op = 1'b0;
         endcase
      end
   endfunction

   // Pin synchronisers and edge history
   always @(posedge mclk) begin
      if (!reset_n) begin
         sync1_reg <= 5'h1F;
         sync2_reg <= 5'h1F;
         sclk_prev_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else begin
         sync1_reg <= {pause_n, guard_n, si, sclk, cs_n};
         sync2_reg <= sync1_reg;
         sclk_prev_reg <= s_sclk;
         cs_prev_reg <= s_cs;
      end
   end

   // Pause tracking; level form gives the deferral to a low clock
   always @* begin
      pause_next = pause_reg;
      if (s_cs) begin
         pause_next = 1'b0; // R21
      end else if (!pause_reg && !s_pause_n && !s_sclk) begin
         pause_next = 1'b1; // R18
      end else if (pause_reg && s_pause_n && !s_sclk) begin
         pause_next = 1'b0; // R19 R22
      end
   end

   // Interface state sequencing
   always @* begin
      state_next = state_reg;
      if (s_cs) begin
         state_next = ST_STANDBY; // R21 R24
      end else if (cs_fall) begin
         state_next = ST_CMD;
      end else if (state_reg == ST_CMD && byte_done &&
         byte_cnt_reg == 3'h0) begin
         if (!known_op(new_byte)) begin
            state_next = ST_IGNORE; // R24
         end else if (dpd_reg && new_byte != `SFG_OP_SIG_READ) begin
            state_next = ST_IGNORE; // R5
         end else if (new_byte == `SFG_OP_STATUS_READ ||
            new_byte == `SFG_OP_SEC_READ) begin
            state_next = ST_OUT;
         end
      end
   end

   // Serial shifting, byte counting, register output
   always @(posedge mclk) begin
      if (!reset_n) begin
         state_reg <= ST_STANDBY; // R1
         pause_reg <= 1'b0;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         opcode_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
         out_reg <= 8'h00;
         so_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pause_reg <= pause_next;
         if (s_cs || cs_fall) begin
            // Select edge or paused release clears the interface
            bit_cnt_reg <= 3'h0; // R21
            byte_cnt_reg <= 3'h0;
         end else if (shift_en) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= new_byte;
            if (bit_cnt_reg == 3'h7) begin
               if (byte_cnt_reg != 3'h7) begin
                  byte_cnt_reg <= byte_cnt_reg + 3'h1;
               end
               if (byte_cnt_reg == 3'h0) begin
                  opcode_reg <= new_byte;
               end else if (byte_cnt_reg < `SFG_LEN_ADDR) begin
                  addr_reg <= {addr_reg[15:0], new_byte};
               end
            end
         end
         // Register image latched as the opcode completes
         if (byte_done && byte_cnt_reg == 3'h0) begin
            if (new_byte == `SFG_OP_SEC_READ) begin
               out_reg <= 8'h00;
               out_reg[`SFG_SEC_FACTORY] <= factory_locked; // R11
               out_reg[`SFG_SEC_CUSTOMER] <= cust_lock_reg; // R13
            end else begin
               out_reg <= {lock_reg, 1'b0, guard_reg, wel_reg, op_busy};
            end
         end else if (out_en && state_reg == ST_OUT) begin
            so_reg <= out_reg[7];
            out_reg <= {out_reg[6:0], out_reg[7]};
         end
      end
   end

   // Command checks at select rise
   reg do_exec; // Pass work to datapath
   reg do_refuse; // Write-type command refused
   reg do_otp; // Redirect to otp area
   always @* begin
      do_exec = 1'b0;
      do_refuse = 1'b0;
      do_otp = 1'b0;
      case (opcode_reg)
         `SFG_OP_PAGE_WRITE: begin
            if (byte_cnt_reg < `SFG_LEN_PAGE_MIN || !wel_reg || op_busy) begin
               do_refuse = 1'b1; // R3 R25
            end else if (otp_reg) begin
               // Locked otp or address past its top is refused
               if (factory_locked || cust_lock_reg || // R14
                  addr_reg[7:0] > {2'b00, `SFG_OTP_TOP}) begin
                  do_refuse = 1'b1;
               end else begin
                  do_exec = 1'b1;
                  do_otp = 1'b1; // R12
               end
            end else if (blk_guarded) begin
               do_refuse = 1'b1; // R6
            end else begin
               do_exec = 1'b1;
            end
         end
         `SFG_OP_SECTOR_WIPE, `SFG_OP_BLOCK_WIPE_A, `SFG_OP_BLOCK_WIPE_B:
         begin
            if (byte_cnt_reg != `SFG_LEN_ADDR || !wel_reg || op_busy ||
               otp_reg || blk_guarded) begin
               do_refuse = 1'b1; // R3 R6 R15 R23 R25
            end else begin
               do_exec = 1'b1;
            end
         end
         `SFG_OP_FULL_WIPE_A, `SFG_OP_FULL_WIPE_B: begin
            if (byte_cnt_reg != `SFG_LEN_SINGLE || !wel_reg || op_busy ||
               otp_reg || any_guarded) begin
               do_refuse = 1'b1; // R3 R6 R15 R23 R25
            end else begin
               do_exec = 1'b1;
            end
         end
         default: do_exec = 1'b0;
      endcase
   end

   // Commit point: select rises, not paused, while taking a command
   wire commit = cs_rise && !pause_reg && state_reg == ST_CMD; // R21
   wire aligned = bit_cnt_reg == 3'h0 && byte_cnt_reg != 3'h0; // R2 R23
   wire one_byte = byte_cnt_reg == `SFG_LEN_SINGLE;
   // Status update blocked by pin guard with lock set
   wire status_shielded = !s_guard_n && lock_reg; // R10 R26

   // Protection state, latch flag and execute pulses
   always @(posedge mclk) begin
      if (!reset_n) begin
         wel_reg <= 1'b0; // R4
         guard_reg <= `SFG_RST_GUARD;
         lock_reg <= `SFG_RST_LOCK;
         otp_reg <= 1'b0;
         cust_lock_reg <= 1'b0;
         dpd_reg <= 1'b0;
         exec_reg <= 1'b0;
         exec_op_reg <= 8'h00;
         exec_addr_reg <= 24'h00_0000;
         exec_otp_reg <= 1'b0;
         exec_region_reg <= 1'b0;
         refuse_reg <= 1'b0;
      end else begin
         exec_reg <= 1'b0;
         refuse_reg <= 1'b0;
         if (commit && !aligned) begin
            refuse_reg <= 1'b1; // R2 R23
         end else if (commit) begin
            case (opcode_reg)
               `SFG_OP_WRITE_ALLOW: begin
                  if (one_byte) wel_reg <= 1'b1; // R3
               end
               `SFG_OP_WRITE_FORBID: begin
                  if (one_byte) wel_reg <= 1'b0; // R4
               end
               `SFG_OP_STATUS_WRITE: begin
                  if (byte_cnt_reg != `SFG_LEN_STATUS || !wel_reg ||
                     op_busy || status_shielded) begin
                     refuse_reg <= 1'b1; // R3 R10 R25 R26
                  end else begin
                     guard_reg <= {addr_reg[5] & size_16mb, addr_reg[4:2]};
                     lock_reg <= addr_reg[`SFG_ST_LOCK];
                     wel_reg <= 1'b0; // R4
                  end
               end
               `SFG_OP_DEEP_DOWN: begin
                  if (one_byte) dpd_reg <= 1'b1;
               end
               `SFG_OP_SIG_READ: dpd_reg <= 1'b0; // R5
               `SFG_OP_OTP_ENTRY: begin
                  if (one_byte) otp_reg <= 1'b1; // R12
               end
               `SFG_OP_OTP_EXIT: begin
                  if (one_byte) otp_reg <= 1'b0; // R12
               end
               `SFG_OP_SEC_WRITE: begin
                  // Only ever sets; nothing clears it but power-up
                  if (one_byte) cust_lock_reg <= 1'b1; // R13 R14
               end
               default: begin
                  refuse_reg <= do_refuse;
                  exec_reg <= do_exec;
                  if (do_exec) begin
                     wel_reg <= 1'b0; // R4
                     exec_op_reg <= opcode_reg;
                     exec_addr_reg <= addr_reg;
                     exec_otp_reg <= do_otp;
                     // Low otp addresses hold the identifier
                     exec_region_reg <= do_otp &&
                        (addr_reg[5:0] > `SFG_OTP_ID_TOP); // R16
                  end
               end
            endcase
         end
      end
   end

   // Pause leaves op_busy and the datapath untouched; shifting stops, the output floats and nothing commits
   assign so_oe = state_reg == ST_OUT && !pause_reg && !s_cs; // R17 R20 R24
   assign so_out = so_reg;
   assign write_latch_flag = wel_reg;
   assign area_guard_bits = guard_reg;
   assign status_lock_bit = lock_reg;
   assign otp_mode = otp_reg;
   assign customer_lock = cust_lock_reg;
   assign deep_powerdown = dpd_reg;
   assign pause_active = pause_reg;
   assign exec_valid = exec_reg;
   assign exec_opcode = exec_op_reg;
   assign exec_addr = exec_addr_reg;
   assign exec_otp = exec_otp_reg;
   assign exec_otp_region = exec_region_reg;
   assign cmd_refused = refuse_reg;
endmodule // sfg_guard_core

// ### dv/sfg_guard_core_assertions.sv
// Checker for the serial flash guard core, bound to its ports
module sfg_guard_core_chk (
   input wire mclk,
   input wire reset_n,
   input wire guard_n,
   input wire op_busy,
   input wire factory_locked,
   input wire so_oe,
   input wire write_latch_flag,
   input wire [3:0] area_guard_bits,
   input wire status_lock_bit,
   input wire otp_mode,
   input wire customer_lock,
   input wire deep_powerdown,
   input wire pause_active,
   input wire exec_valid,
   input wire exec_otp,
   input wire cmd_refused
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks live in the one mclk domain
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_exec_latch: assert property (exec_valid |-> $past(write_latch_flag))
      else $error("execute without latch flag");
   a_exec_clear: assert property (exec_valid |-> !write_latch_flag)
      else $error("latch flag kept after execute");
   a_deep_latch: assert property (
      $rose(write_latch_flag) |-> !$past(deep_powerdown))
      else $error("latch flag set in deep power-down");
   a_one_answer: assert property (!(exec_valid && cmd_refused))
      else $error("execute and refuse together");
   a_exec_idle: assert property (exec_valid |-> !$past(op_busy))
      else $error("execute while operation runs");
   a_exec_otp: assert property (
      exec_valid |-> exec_otp == $past(otp_mode))
      else $error("otp routing differs from otp mode");
   // Locked otp takes no more writes, lock never drops
   a_otp_frozen: assert property (exec_valid && exec_otp |->
      !$past(customer_lock) && !$past(factory_locked))
      else $error("write into locked otp");
   a_lock_hold: assert property ($past(customer_lock) |-> customer_lock)
      else $error("customer lock dropped");
   a_pause_float: assert property (pause_active |-> !so_oe)
      else $error("output driven during pause");
   // Pin low for a while with lock set: guard field frozen
   a_guard_frozen: assert property (!guard_n && !$past(guard_n, 3)
      && status_lock_bit |=> $stable(area_guard_bits))
      else $error("guard bits changed while pin guarded");

   c_exec: cover property (exec_valid);
   c_refused: cover property (cmd_refused);
   c_pause: cover property (pause_active);
   c_deep: cover property (deep_powerdown);
endmodule // sfg_guard_core_chk

bind sfg_guard_core sfg_guard_core_chk u_sfg_guard_core_chk (
   .mclk(mclk), .reset_n(reset_n), .guard_n(guard_n), .op_busy(op_busy),
   .factory_locked(factory_locked), .so_oe(so_oe),
   .write_latch_flag(write_latch_flag), .area_guard_bits(area_guard_bits),
   .status_lock_bit(status_lock_bit), .otp_mode(otp_mode),
   .customer_lock(customer_lock), .deep_powerdown(deep_powerdown),
   .pause_active(pause_active), .exec_valid(exec_valid),
   .exec_otp(exec_otp), .cmd_refused(cmd_refused));

// ### dv/sfg_host_model.sv
// Host controller model driving the serial link in mode 0
module sfg_host_model (
   input wire mclk,
   input wire so,
   output logic cs_n,
   output logic sclk,
   output logic si,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 8; // 160 ns link clock period

   // Idle link: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b1;
   end

   // Reply bits taken on each rise, last eight kept, msb first
   always @(posedge sclk) begin
      rx <= {rx[6:0], so};
   end

   // Wait n cycles, changes land on the falling edge
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // One frame, first nb bits of d msb first; clock still outside it
   task automatic frame(input logic [39:0] d, input int nb);
      cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         si = d[39 - i];
         idle(HALF);
         sclk = 1'b1;
         idle(HALF);
         sclk = 1'b0;
      end
      idle(HALF);
      cs_n = 1'b1;
      si = ~si; // Stale level would hide a sampling slip
      idle(2 * HALF);
   endtask
endmodule // sfg_host_model

// ### dv/tb_serial_flash_write_guard_hold.sv
// Self-checking bench for the serial flash guard core
`include "sfg_defines.vh"
`define CHK(nm, ex, got) \
   begin \
      n_tests++; \
      if ((got) !== (ex)) begin \
         err_total++; \
         $display("Error %s expected %h seen %h", nm, ex, got); \
      end \
   end

module tb_serial_flash_write_guard_hold;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, reset_n, guard_n, pause_n, size_16mb, factory_locked, op_busy;
   wire cs_n, sclk, si, so_out, so_oe, write_latch_flag, status_lock_bit;
   wire otp_mode, customer_lock, deep_powerdown, pause_active, exec_valid;
   wire exec_otp, exec_otp_region, cmd_refused;
   wire [3:0] area_guard_bits;
   wire [7:0] exec_opcode;
   wire [23:0] exec_addr;
   wire [7:0] rx_byte;
   // Released output floats up to the pull-up level
   wire so_line = so_oe ? so_out : 1'b1;
   int err_total, n_tests, ev_n, rf_n, fb;
   logic [7:0] ev_op;
   logic [23:0] ev_ad;

   sfg_host_model u_sfg_host_model (.mclk(mclk), .so(so_line), .cs_n(cs_n),
      .sclk(sclk), .si(si), .rx(rx_byte));
   sfg_guard_core u_sfg_guard_core (.mclk(mclk), .reset_n(reset_n),
      .cs_n(cs_n), .sclk(sclk), .si(si), .guard_n(guard_n),
      .pause_n(pause_n), .size_16mb(size_16mb),
      .factory_locked(factory_locked), .op_busy(op_busy), .so_out(so_out),
      .so_oe(so_oe), .write_latch_flag(write_latch_flag),
      .area_guard_bits(area_guard_bits), .status_lock_bit(status_lock_bit),
      .otp_mode(otp_mode), .customer_lock(customer_lock),
      .deep_powerdown(deep_powerdown), .pause_active(pause_active),
      .exec_valid(exec_valid), .exec_opcode(exec_opcode),
      .exec_addr(exec_addr), .exec_otp(exec_otp),
      .exec_otp_region(exec_otp_region), .cmd_refused(cmd_refused));

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Count one-cycle answers so pulses are never missed
   always @(posedge mclk) begin
      if (exec_valid) begin
         ev_n++;
         ev_op = exec_opcode;
         ev_ad = exec_addr;
      end
      if (cmd_refused)
         rf_n++;
   end

   task automatic conclude();
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic sf(input logic [39:0] d, input int nb);
      u_sfg_host_model.frame(d, nb);
   endtask
   task automatic wen();
      sf({`SFG_OP_WRITE_ALLOW, 32'h0}, 8);
   endtask
   task automatic st(input logic [7:0] v);
      wen();
      sf({`SFG_OP_STATUS_WRITE, v, 24'h0}, 16);
   endtask
   // Write-type command with fresh counters; page carries one data byte
   task automatic wr(input logic [7:0] op, input logic [23:0] a, int nb);
      wen();
      ev_n = 0;
      rf_n = 0;
      sf({op, a, 8'h0}, nb);
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      err_total++;
      conclude();
   end

   initial begin
      {reset_n, pause_n, size_16mb, factory_locked, op_busy} = 5'h08;
      guard_n = 1'b1;
      repeat (20) @(negedge mclk);
      reset_n = 1'b1;
      u_sfg_host_model.idle(4);
      `CHK("latch", 1'b0, write_latch_flag)
      `CHK("otp", 1'b0, otp_mode)
      `CHK("guard", 4'h0, area_guard_bits)
      ev_n = 0;
      rf_n = 0;
      sf({`SFG_OP_PAGE_WRITE, 24'h00_0100, 8'h5A}, 40);
      `CHK("no_latch", 1, rf_n)
      wen();
      `CHK("latch", 1'b1, write_latch_flag)
      sf({`SFG_OP_WRITE_FORBID, 32'h0}, 8);
      `CHK("latch", 1'b0, write_latch_flag)
      for (int nb = 7; nb <= 9; nb += 2) begin
         sf({`SFG_OP_WRITE_ALLOW, 32'h0}, nb);
         `CHK("ragged", 1'b0, write_latch_flag)
      end
      $display("Test latch finished");
      // Each level: first guarded block refused, the one below accepted for levels 1 to 4
      for (int g = 1; g <= 7; g++) begin
         st(8'(g << 2));
         `CHK("guard", 4'(g), area_guard_bits)
         `CHK("latch", 1'b0, write_latch_flag)
         fb = (g > 4) ? 0 : 16 - (1 << (g - 1));
         wr(`SFG_OP_SECTOR_WIPE, 24'(fb << 16), 32);
         `CHK("guarded", 1, rf_n)
         if (fb > 0) begin
            wr(`SFG_OP_BLOCK_WIPE_B, 24'((fb - 1) << 16), 32);
            `CHK("exec", 1, ev_n)
            `CHK("addr", 24'((fb - 1) << 16), ev_ad)
            `CHK("op", `SFG_OP_BLOCK_WIPE_B, ev_op)
            `CHK("latch", 1'b0, write_latch_flag)
         end
      end
      wr(`SFG_OP_FULL_WIPE_A, 24'h0, 8);
      `CHK("full_guarded", 1, rf_n)
      st(8'h84);
      guard_n = 1'b0;
      st(8'h00);
      `CHK("pin_guard", 4'h1, area_guard_bits)
      `CHK("lock", 1'b1, status_lock_bit)
      sf({`SFG_OP_STATUS_READ, 32'h0}, 16);
      `CHK("status", 8'h86, rx_byte)
      guard_n = 1'b1;
      st(8'h00);
      wr(`SFG_OP_FULL_WIPE_B, 24'h0, 8);
      `CHK("full", 1, ev_n)
      op_busy = 1'b1;
      wr(`SFG_OP_SECTOR_WIPE, 24'h0, 32);
      `CHK("busy", 0, ev_n)
      op_busy = 1'b0;
      $display("Test guard finished");
      // Refused wipe left the latch set; clear it first
      sf({`SFG_OP_WRITE_FORBID, 32'h0}, 8);
      sf({`SFG_OP_DEEP_DOWN, 32'h0}, 8);
      `CHK("deep", 1'b1, deep_powerdown)
      wen();
      `CHK("deep_latch", 1'b0, write_latch_flag)
      sf({`SFG_OP_SIG_READ, 32'h0}, 8);
      `CHK("wake", 1'b0, deep_powerdown)
      sf({`SFG_OP_OTP_ENTRY, 32'h0}, 8);
      `CHK("otp", 1'b1, otp_mode)
      wr(`SFG_OP_SECTOR_WIPE, 24'h0, 32);
      `CHK("otp_array", 0, ev_n)
      wr(`SFG_OP_PAGE_WRITE, 24'h00_0012, 40);
      `CHK("otp_page", 1'b1, exec_otp)
      `CHK("region", 1'b1, exec_otp_region)
      wr(`SFG_OP_PAGE_WRITE, 24'h00_000F, 40);
      `CHK("region", 1'b0, exec_otp_region)
      wr(`SFG_OP_PAGE_WRITE, 24'h00_0040, 40);
      `CHK("otp_top", 1, rf_n)
      sf({`SFG_OP_SEC_WRITE, 32'h0}, 8);
      `CHK("cust", 1'b1, customer_lock)
      sf({`SFG_OP_SEC_READ, 32'h0}, 16);
      `CHK("security", 8'h02, rx_byte)
      wr(`SFG_OP_PAGE_WRITE, 24'h00_0010, 40);
      `CHK("locked", 0, ev_n)
      sf({`SFG_OP_OTP_EXIT, 32'h0}, 8);
      `CHK("otp", 1'b0, otp_mode)
      $display("Test otp finished");
      // Refused page left the latch set; clear it first
      sf({`SFG_OP_WRITE_FORBID, 32'h0}, 8);
      // Pause asked with clock high: starts at the fall, one rise lost
      fork
         wen();
         begin
            u_sfg_host_model.idle(44);
            pause_n = 1'b0;
            u_sfg_host_model.idle(12);
            `CHK("pause", 1'b1, pause_active)
            `CHK("float", 1'b0, so_oe)
            pause_n = 1'b1;
            u_sfg_host_model.idle(4);
            `CHK("pause_hold", 1'b1, pause_active)
         end
      join
      `CHK("lost_bit", 1'b0, write_latch_flag)
      wen();
      `CHK("resume", 1'b1, write_latch_flag)
      $display("Test pause finished");
      conclude();
   end
endmodule // tb_serial_flash_write_guard_hold
